// ==== rtl/drf_refresh_core.v ====
// refresh scheduling and self-refresh state of the memory device
// Functional notes
// - clock-enable low keeps self refresh; other inputs ignored there
// - device retains data by own timer, clock off, refreshes within minimum stay
// - exit settle time starts at third edge after clock-enable high, behind the two-flop synchroniser
// - no refresh performed in power-down
// - four-bit bank mask written by mode-register write at address 10h
// - masked bank gets no self refresh; its data not retained
// - unmasked bank coverage follows segment mask bits
`timescale 1ns/1ps
`include "drf_regs.vh"
module drf_refresh_core (
    input  wire       clk,
    input  wire       rst,
    input  wire       cke,
    input  wire       cs_n,
    input  wire [9:0] cmd_addr_bus,
    input  wire [3:0] segment_ok,
    output reg        in_self_refresh_ff,
    output reg        in_power_down_ff,
    output reg        exit_settle_ff,
    output wire       int_clk_en,
    output wire [3:0] bank_refresh,
    output wire [3:0] bank_mask,
    output reg        cmd_error_ff
);
    localparam ST_IDLE   = 2'd0;
    localparam ST_SREF   = 2'd1;
    localparam ST_PDOWN  = 2'd2;
    localparam ST_SETTLE = 2'd3;

    // =========================================
    // timing constants
    localparam [7:0]   MASK_RST  = `DRF_BANK_MASK_RST;
    localparam integer CKESR_I   = `DRF_CKESR_CYC;
    localparam integer XSR_I     = `DRF_XSR_CYC;
    localparam [7:0]   CKESR_CYC = CKESR_I[7:0];
    localparam [7:0]   XSR_CYC   = XSR_I[7:0];

    // state and engine handshake, declared here since the mask logic reads the state
    reg  [1:0] state_ff;
    wire       eng_busy;
    wire       eng_start;

    // =========================================
    // input synchronisers
    reg        cke_s1_ff, cke_ff, cs_s1_ff, cs_ff;
    reg [9:0]  ca_s1_ff, ca_ff;
    reg        cke_prev_ff;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cke_s1_ff   <= 1'b0;
            cke_ff      <= 1'b0;
            cs_s1_ff    <= 1'b1;
            cs_ff       <= 1'b1;
            ca_s1_ff    <= 10'h000;
            ca_ff       <= 10'h000;
            cke_prev_ff <= 1'b0;
        end else begin
            cke_s1_ff   <= cke;
            cke_ff      <= cke_s1_ff;
            cs_s1_ff    <= cs_n;
            cs_ff       <= cs_s1_ff;
            ca_s1_ff    <= cmd_addr_bus;
            ca_ff       <= ca_s1_ff;
            cke_prev_ff <= cke_ff;
        end
    end

    // =========================================
    // command decode
    function is_ref_code;
        input [9:0] ca;
        begin
            is_ref_code = (ca[2:0] == `DRF_CMD_REF_CA);
        end
    endfunction
    function is_nop;
        input       csn;
        input [9:0] ca;
        begin
            is_nop = csn | (ca[2:0] == 3'b111);
        end
    endfunction
    wire sref_entry = cke_prev_ff & ~cke_ff & ~cs_ff & is_ref_code(ca_ff);
    wire pd_entry   = cke_prev_ff & ~cke_ff & ~sref_entry;
    wire refresh_all_banks_cmd  = cke_prev_ff & cke_ff & ~cs_ff & is_ref_code(ca_ff) & ca_ff[`DRF_CMD_REF_ALL_BIT];
    wire mrw_cmd    = cke_prev_ff & cke_ff & ~cs_ff & (ca_ff[3:0] == `DRF_CMD_MRW_CA);

    // =========================================
    // bank mask register
    // written only from idle, so a write during self refresh cannot change retention
    reg [3:0] mask_ff;
    reg       mrw_addr_ok_ff;
    reg       mrw_phase_ff;
    assign bank_mask = mask_ff;
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            mask_ff        <= MASK_RST[3:0];
            mrw_phase_ff   <= 1'b0;
            mrw_addr_ok_ff <= 1'b0;
        end else if (mrw_phase_ff) begin
            // second half carries data; low four bits are the bank mask
            if (mrw_addr_ok_ff) mask_ff <= ca_ff[`DRF_BANK_MASK_W-1:0];
            mrw_phase_ff <= 1'b0;
        end else if (mrw_cmd && state_ff == ST_IDLE) begin
            mrw_phase_ff   <= 1'b1;
            mrw_addr_ok_ff <= ({ca_ff[9:4], 2'b00} == (`DRF_MA_BANK_MASK & 8'hfc)) &&
                              (ca_ff[9:4] == 6'h04);
        end
    end

    // =========================================
    // power state machine
    reg [15:0] tick_ff;
    reg [7:0]  stay_ff;
    reg [7:0]  settle_ff;
    reg        sr_refresh_done_ff;
    wire       sr_tick = (state_ff == ST_SREF) && (tick_ff == 16'h0000);
    wire       first_ref = (state_ff == ST_SREF) && !sr_refresh_done_ff;
    // self-refresh timer runs from reset clock here; a stopped pin clock is modelled by the enable output
    assign int_clk_en = (state_ff == ST_IDLE) || (state_ff == ST_SETTLE);
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            state_ff           <= ST_IDLE;
            tick_ff            <= 16'h0000;
            stay_ff            <= 8'h00;
            settle_ff          <= 8'h00;
            sr_refresh_done_ff <= 1'b0;
            in_self_refresh_ff <= 1'b0;
            in_power_down_ff   <= 1'b0;
            exit_settle_ff     <= 1'b0;
            cmd_error_ff       <= 1'b0;
        end else begin
            case (state_ff)
                ST_IDLE: begin
                    if (sref_entry) begin
                        state_ff           <= ST_SREF;
                        in_self_refresh_ff <= 1'b1;
                        stay_ff            <= CKESR_CYC;
                        tick_ff            <= `DRF_SR_TICK_CYC;
                        sr_refresh_done_ff <= 1'b0;
                    end else if (pd_entry) begin
                        state_ff         <= ST_PDOWN;
                        in_power_down_ff <= 1'b1;
                    end
                end
                ST_SREF: begin
                    // only clock-enable is watched here
                    if (stay_ff != 8'h00) stay_ff <= stay_ff - 8'h01;
                    if (eng_start) sr_refresh_done_ff <= 1'b1;
                    tick_ff <= (tick_ff == 16'h0000) ? `DRF_SR_TICK_CYC : tick_ff - 16'h0001;
                    if (cke_ff) begin
                        state_ff           <= ST_SETTLE;
                        in_self_refresh_ff <= 1'b0;
                        exit_settle_ff     <= 1'b1;
                        settle_ff          <= XSR_CYC;
                        // sticky until reset so one early exit stays visible
                        if (stay_ff != 8'h00) cmd_error_ff <= 1'b1;
                    end
                end
                ST_PDOWN: begin
                    // no timer runs here, refresh stays with the controller
                    if (cke_ff) begin
                        state_ff         <= ST_IDLE;
                        in_power_down_ff <= 1'b0;
                    end
                end
                default: begin
                    if (settle_ff != 8'h00) settle_ff <= settle_ff - 8'h01;
                    if (!cke_ff) begin
                        // re-entry is the one allowed break in the settle time
                        state_ff           <= ST_SREF;
                        exit_settle_ff     <= 1'b0;
                        in_self_refresh_ff <= 1'b1;
                        stay_ff            <= CKESR_CYC;
                        tick_ff            <= `DRF_SR_TICK_CYC;
                        sr_refresh_done_ff <= 1'b0;
                    end else begin
                        if (!is_nop(cs_ff, ca_ff)) cmd_error_ff <= 1'b1;
                        if (settle_ff == 8'h01 || settle_ff == 8'h00) begin
                            state_ff       <= ST_IDLE;
                            exit_settle_ff <= 1'b0;
                        end
                    end
                end
            endcase
        end
    end

    // first internal refresh starts in the first self-refresh cycle if the engine is idle, the one cycle of the minimum stay
    assign eng_start = ((first_ref || sr_tick) && !eng_busy) ||
                       (refresh_all_banks_cmd && state_ff == ST_IDLE);
    drf_bank_refresh drf_bank_refresh_i (
        .clk             (clk),
        .rst             (rst),
        .start           (eng_start),
        .in_self_refresh (state_ff == ST_SREF),
        .bank_mask       (mask_ff),
        .segment_ok      (segment_ok),
        .bank_refresh_ff (bank_refresh),
        .busy            (eng_busy)
    );
endmodule // drf_refresh_core

// ==== rtl/drf_regs.vh ====
// constants for the dram refresh and self-refresh block
`ifndef DRF_REGS_VH
`define DRF_REGS_VH
`define DRF_MA_BANK_MASK     8'h10
`define DRF_BANK_MASK_RST    8'h00
`define DRF_BANK_MASK_W      4
`define DRF_CMD_REF_CA       3'b100
`define DRF_CMD_REF_ALL_BIT  3
`define DRF_CMD_MRW_CA       4'b0000
`define DRF_CLK_MHZ          20
`define DRF_CKESR_NS         15
`define DRF_CKESR_CYC        (((`DRF_CKESR_NS * `DRF_CLK_MHZ) + 999) / 1000)
`define DRF_XSR_NS           140
`define DRF_XSR_CYC          (((`DRF_XSR_NS * `DRF_CLK_MHZ) + 999) / 1000)
`define DRF_RFC_NS           130
`define DRF_RFC_CYC          (((`DRF_RFC_NS * `DRF_CLK_MHZ) + 999) / 1000)
`define DRF_SR_TICK_CYC      16'h0004
`define DRF_NUM_BANKS        4
`endif

// ==== rtl/drf_bank_refresh.v ====
// internal all-bank refresh engine with per-bank masking
`timescale 1ns/1ps
`include "drf_regs.vh"
module drf_bank_refresh (
    input  wire       clk,
    input  wire       rst,
    input  wire       start,
    input  wire       in_self_refresh,
    input  wire [3:0] bank_mask,
    input  wire [3:0] segment_ok,
    output reg  [3:0] bank_refresh_ff,
    output wire       busy
);
    localparam integer RFC_I   = `DRF_RFC_CYC;
    localparam [7:0]   RFC_CYC = RFC_I[7:0];
    reg [7:0] cnt_ff;
    wire [3:0] nxt_bank;
    assign busy = (cnt_ff != 8'h00);
    genvar g;
    // =========================================
    // per-bank gating
    generate
        for (g = 0; g < `DRF_NUM_BANKS; g = g + 1) begin : g_bank
            // masked bank never refreshed in self refresh, else segment bits decide
            assign nxt_bank[g] = start & ~(in_self_refresh & bank_mask[g])
                               & (~in_self_refresh | segment_ok[g]);
        end
    endgenerate
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            cnt_ff          <= 8'h00;
            bank_refresh_ff <= 4'h0;
        end else begin
            if (start && !busy) begin
                cnt_ff          <= RFC_CYC;
                bank_refresh_ff <= nxt_bank;
            end else begin
                if (busy) cnt_ff <= cnt_ff - 8'h01;
                bank_refresh_ff <= 4'h0;
            end
        end
    end
endmodule // drf_bank_refresh

// ==== verif/drf_refresh_core_assertions.sv ====
// concurrent checks on the refresh core ports
`timescale 1ns/1ps
module drf_refresh_core_assertions (
    input wire       clk,
    input wire       rst,
    input wire       cke,
    input wire       cs_n,
    input wire [9:0] cmd_addr_bus,
    input wire [3:0] segment_ok,
    input wire       in_self_refresh_ff,
    input wire       in_power_down_ff,
    input wire       exit_settle_ff,
    input wire       int_clk_en,
    input wire [3:0] bank_refresh,
    input wire [3:0] bank_mask,
    input wire       cmd_error_ff
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);
    // ==========
    // entry sequence: idle with clock-enable high, then the entry command
    sequence s_entry;
        cke && !in_self_refresh_ff && !in_power_down_ff && !exit_settle_ff
        ##1 !cke && !cs_n && cmd_addr_bus[2:0] == 3'b100;
    endsequence
    sequence s_held_low;
        !cke [*4];
    endsequence
    a_entry_takes: assert property (s_entry ##1 s_held_low |-> ##[0:2] in_self_refresh_ff)
        else $error("self refresh not entered");
    a_refresh_in_stay: assert property ($rose(in_self_refresh_ff) && (segment_ok & ~bank_mask) != 4'h0
        |-> ##[0:3] bank_refresh != 4'h0) else $error("no refresh after entry");
    a_mask_blocks: assert property (in_self_refresh_ff |-> (bank_refresh & bank_mask) == 4'h0)
        else $error("masked bank refreshed");
    a_segment_gate: assert property (in_self_refresh_ff |-> (bank_refresh & ~segment_ok) == 4'h0)
        else $error("uncovered bank refreshed");
    a_no_pd_refresh: assert property (in_power_down_ff |-> bank_refresh == 4'h0)
        else $error("refresh in power-down");
    a_clock_gated: assert property (in_self_refresh_ff || in_power_down_ff |-> !int_clk_en)
        else $error("internal clock on");
    a_stays_in_sr: assert property (in_self_refresh_ff && !cke && !$past(cke) && !$past(cke, 2)
        && !$past(cke, 3) |=> in_self_refresh_ff) else $error("left self refresh early");
    a_settle_follows: assert property ($fell(in_self_refresh_ff) |-> ##[0:1] exit_settle_ff)
        else $error("no exit settle");
    a_settle_length: assert property ($rose(exit_settle_ff) |-> exit_settle_ff [*3])
        else $error("exit settle too short");
endmodule // drf_refresh_core_assertions
bind drf_refresh_core drf_refresh_core_assertions u_chk (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n),
    .cmd_addr_bus(cmd_addr_bus), .segment_ok(segment_ok), .in_self_refresh_ff(in_self_refresh_ff),
    .in_power_down_ff(in_power_down_ff), .exit_settle_ff(exit_settle_ff), .int_clk_en(int_clk_en),
    .bank_refresh(bank_refresh), .bank_mask(bank_mask), .cmd_error_ff(cmd_error_ff));

// ==== verif/drf_ctrl_model.sv ====
// memory controller model driving the command pins
`timescale 1ns/1ps
`include "drf_regs.vh"
module drf_ctrl_model (
    input  wire       clk,
    output reg        cke,
    output reg        cs_n,
    output reg  [9:0] cmd_addr_bus
);
    initial begin
        cke = 1'b1;
        cs_n = 1'b1;
        cmd_addr_bus = 10'h000;
    end
    // refresh bookkeeping kept on the controller side
    localparam integer WINDOW_CYC  = 4000;
    localparam integer AVG_INT_CYC = 40;
    integer            ref_cnt     = 0;
    integer            sr_credit   = 0;
    task cyc(input c, input s, input [9:0] ca);
        begin
            @(negedge clk);
            cke = c;
            cs_n = s;
            cmd_addr_bus = ca;
        end
    endtask
    // don't-care lines toggle so a stale value never looks valid
    task nop(input integer n);
        repeat (n) cyc(1'b1, 1'b1, ~cmd_addr_bus);
    endtask
    task mode_reg_write(input [3:0] m);
        begin
            cyc(1'b1, 1'b0, 10'h040);
            cyc(1'b1, 1'b0, {6'h00, m});
            nop(1);
        end
    endtask
    // spacing keeps the burst rate limit and banks idle afterwards
    task refresh_all_banks;
        begin
            cyc(1'b1, 1'b0, 10'h00c);
            nop(`DRF_RFC_CYC + 4);
            ref_cnt = ref_cnt + 1;
        end
    endtask
    // back-to-back refreshes no faster than the burst window allows
    task burst(input integer n);
        repeat (n) begin
            refresh_all_banks;
            nop(3 * `DRF_RFC_CYC);
        end
    endtask
    // a pause after a burst of n never outlasts the window less n burst slots
    task pause(input integer n, input integer len);
        begin
            if (len > WINDOW_CYC - n * 4 * `DRF_RFC_CYC)
                len = WINDOW_CYC - n * 4 * `DRF_RFC_CYC;
            nop(len);
        end
    endtask
    // regular pattern is started straight after a self-refresh stay, never after a pause
    task regular(input integer n);
        repeat (n) begin
            refresh_all_banks;
            nop(AVG_INT_CYC);
        end
    endtask
    task sr_stay(input integer n);
        begin
            if (ref_cnt == 0) burst(1);
            nop(1);
            cyc(1'b0, 1'b0, 10'h004);
            cyc(1'b0, 1'b1, ~cmd_addr_bus);
            repeat (n) cyc(1'b0, $urandom, $urandom);
            sr_credit = sr_credit + (n + AVG_INT_CYC - 1) / AVG_INT_CYC;
            nop(`DRF_XSR_CYC + 6);
            refresh_all_banks;
        end
    endtask
endmodule // drf_ctrl_model

// ==== verif/drf_refresh_core_bench.sv ====
// self-checking bench for the refresh core
`timescale 1ns/1ps
module drf_refresh_core_bench;
    reg         clk;
    reg         rst;
    reg  [3:0]  segment_ok;
    reg  [3:0]  m;
    reg  [3:0]  exp_q[$];
    reg         sr_d;
    wire        cke;
    wire        cs_n;
    wire [9:0]  ca;
    wire        sr;
    wire        pd;
    wire [3:0]  br;
    wire [3:0]  bm;
    wire        err;
    integer     n_errors = 0;
    integer     comparisons = 0;
    integer     k;
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    drf_ctrl_model drf_ctrl_model_i (.clk(clk), .cke(cke), .cs_n(cs_n), .cmd_addr_bus(ca));
    drf_refresh_core drf_refresh_core_i (.clk(clk), .rst(rst), .cke(cke), .cs_n(cs_n), .cmd_addr_bus(ca),
        .segment_ok(segment_ok), .in_self_refresh_ff(sr), .in_power_down_ff(pd), .exit_settle_ff(),
        .int_clk_en(), .bank_refresh(br), .bank_mask(bm), .cmd_error_ff(err));
    task check(input [3:0] seen, input [3:0] want);
        begin
            comparisons = comparisons + 1;
            if (seen !== want) begin
                n_errors = n_errors + 1;
                $display("[ERR] %0t got %h expected %h", $time, seen, want);
            end
        end
    endtask
    task finish_test;
        begin
            $display("errors %0d comparisons %0d", n_errors, comparisons);
            if (n_errors == 0 && comparisons > 0)
                $display("Testbench passed");
            else
                $display("Testbench failed");
            $finish;
        end
    endtask
    // each self-refresh stay owns one note, dropped when the stay ends
    always @(posedge clk) begin
        #1;
        if (sr === 1'b1 && br !== 4'h0 && exp_q.size() > 0)
            check(br, exp_q[0]);
        // outside self refresh a refresh covers every bank whatever the mask
        if (sr === 1'b0 && sr_d === 1'b0 && br !== 4'h0)
            check(br, 4'hf);
        if (sr_d === 1'b1 && sr === 1'b0 && exp_q.size() > 0)
            exp_q.pop_front();
        sr_d = sr;
    end
    initial begin
        rst = 1'b1;
        sr_d = 1'b0;
        segment_ok = 4'h0;
        k = $urandom(91);
        repeat (2) @(posedge clk);
        @(negedge clk) rst = 1'b0;
        drf_ctrl_model_i.nop(6);
        for (k = 0; k < 5; k = k + 1) begin
            m = (k == 0) ? 4'hf : (k == 1) ? 4'h0 : $urandom;
            @(negedge clk) segment_ok = (k == 1) ? 4'hf : $urandom;
            drf_ctrl_model_i.mode_reg_write(m);
            drf_ctrl_model_i.nop(6);
            check(bm, m);
            drf_ctrl_model_i.burst(2);
            exp_q.push_back(~m & segment_ok);
            drf_ctrl_model_i.sr_stay(20);
            check(bm, m);
            check({3'b000, sr}, 4'h0);
        end
        drf_ctrl_model_i.regular(2);
        drf_ctrl_model_i.burst(2);
        drf_ctrl_model_i.pause(2, 30);
        repeat (12) drf_ctrl_model_i.cyc(1'b0, 1'b1, $urandom);
        check({3'b000, pd}, 4'h1);
        drf_ctrl_model_i.nop(8);
        check({3'b000, pd}, 4'h0);
        check({3'b000, err}, 4'h0);
        // a command inside the exit settle time must raise the sticky error
        exp_q.push_back(~m & segment_ok);
        drf_ctrl_model_i.nop(1);
        drf_ctrl_model_i.cyc(1'b0, 1'b0, 10'h004);
        repeat (5) drf_ctrl_model_i.cyc(1'b0, 1'b1, $urandom);
        drf_ctrl_model_i.cyc(1'b1, 1'b1, 10'h000);
        drf_ctrl_model_i.cyc(1'b1, 1'b0, 10'h00c);
        drf_ctrl_model_i.nop(8);
        check({3'b000, err}, 4'h1);
        // a second reset clears the sticky error and the mask
        @(negedge clk) rst = 1'b1;
        repeat (2) @(negedge clk);
        rst = 1'b0;
        drf_ctrl_model_i.nop(4);
        check({3'b000, err}, 4'h0);
        check(bm, 4'h0);
        finish_test;
    end
    initial begin
        // about six times the expected run
        #200000;
        n_errors = n_errors + 1;
        finish_test;
    end
endmodule // drf_refresh_core_bench
